// ### core/tam_pkg.sv
// Constants, register map and carrier types of the thermal alert monitor.
// Assumes a simple memory-mapped register port on the controller clock.
`default_nettype none
package tam_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [15:0] TAM_OFF_THROTTLE_LEVELS_ENABLE  = 16'h1528;
  localparam logic [15:0] TAM_OFF_AHT   = 16'h1530;
  localparam logic [15:0] TAM_OFF_ALT   = 16'h1534;
  localparam logic [15:0] TAM_OFF_TRIP  = 16'h1538;
  localparam logic [15:0] TAM_OFF_HOT   = 16'h1540;
  localparam logic [15:0] TAM_OFF_SENS0 = 16'h1560;
  localparam logic [15:0] TAM_SENS_STEP = 16'h0004;
  localparam int TAM_NSENS = 3;
  localparam int TAM_TW    = 9;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int TAM_LOCK_BIT     = 31;
  localparam int TAM_RISE_EVT_BIT = 7;
  localparam int TAM_FALL_EVT_BIT = 15;
  localparam int TAM_RISE_ID_LSB  = 0;
  localparam int TAM_FALL_ID_LSB  = 8;
  localparam int TAM_HOT_EN_BIT   = 15;
  localparam int TAM_MASK_BIT     = 16;
  localparam int TAM_VALID_BIT    = 9;
  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [8:0] TAM_AHT_RST = 9'h0ff;
  localparam logic [8:0] TAM_ALT_RST = 9'h000;
  localparam logic [8:0] TAM_HOT_RST = 9'h000;
  // ************************************************************
  // Types
  // ************************************************************
  typedef logic signed [8:0] tam_temp_t;
  typedef struct packed {
    logic        valid;
    tam_temp_t   temp;
  } tam_sens_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } tam_req_t;
endpackage
`default_nettype wire

// ### core/tam_monitor.sv
// Thermal alert monitor: thresholds, trip status, hot pin and sensor registers.
// Assumes sensor readings already on clk; register port single cycle, read data next cycle.
`default_nettype none
module tam_monitor
  import tam_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire tam_req_t             req,
  output logic [31:0]               rdata,
  input  wire tam_sens_t [TAM_NSENS-1:0] sensIn,
  output logic                      hotAlertPinN,
  output logic                      systemMgmtInterrupt,
  output logic                      acpiControlInterrupt,
  input  wire logic                 sciSelect
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic                 throttle_enable_lock;
    tam_temp_t            aht;
    tam_temp_t            alt;
    logic                 riseEvt;
    logic                 fallEvt;
    logic                 riseSeen;
    logic [3:0]           riseId;
    logic [3:0]           fallId;
    logic                 hotLock;
    logic                 hotEn;
    tam_temp_t            hotThr;
    logic [TAM_NSENS-1:0] sensLock;
    logic [TAM_NSENS-1:0] sensMask;
    logic                 aboveHi;
    logic                 belowLo;
    logic                 hotN;
    logic                 system_mgmt_interrupt;
    logic                 acpi_control_interrupt;
    logic [31:0]          rdata;
  } tam_state_t;

  tam_state_t state_q;
  tam_state_t state_d;

  // ************************************************************
  // Helper functions
  // ************************************************************
  // Signed compare; a plain compare of the raw bits would put -1 above +1
  function automatic logic tam_gt(input tam_temp_t a, input tam_temp_t b);
    return $signed(a) > $signed(b);
  endfunction

  // Address match for one register
  function automatic logic tam_hit(input logic [15:0] addr, input logic [15:0] off);
    return addr == off;
  endfunction

  // Byte offset of one sensor register
  function automatic logic [15:0] tam_sens_off(input int idx);
    logic [31:0] wide;
    wide = 32'(TAM_OFF_SENS0) + 32'(TAM_SENS_STEP) * 32'(idx);
    return wide[15:0];
  endfunction

  // Word of a lock-only register; bits below the lock read zero
  function automatic logic [31:0] tam_lock_word(input logic lock);
    logic [31:0] w;
    w               = '0;
    w[TAM_LOCK_BIT] = lock;
    return w;
  endfunction

  // Word of an alert threshold register
  function automatic logic [31:0] tam_thr_word(input tam_temp_t thr);
    logic [31:0] w;
    w             = '0;
    w[TAM_TW-1:0] = thr;
    return w;
  endfunction

  // Word of the trip status register
  function automatic logic [31:0] tam_trip_word(input logic       fallEvt,
                                                input logic [3:0] fallId,
                                                input logic       riseEvt,
                                                input logic [3:0] riseId);
    logic [31:0] w;
    w                       = '0;
    w[TAM_FALL_EVT_BIT]     = fallEvt;
    w[TAM_FALL_ID_LSB +: 4] = fallId;
    w[TAM_RISE_EVT_BIT]     = riseEvt;
    w[TAM_RISE_ID_LSB +: 4] = riseId;
    return w;
  endfunction

  // Word of the hot-level control register
  function automatic logic [31:0] tam_hot_word(input logic      lock,
                                               input logic      en,
                                               input tam_temp_t thr);
    logic [31:0] w;
    w                 = '0;
    w[TAM_LOCK_BIT]   = lock;
    w[TAM_HOT_EN_BIT] = en;
    w[TAM_TW-1:0]     = thr;
    return w;
  endfunction

  // Word of one sensor control and status register
  function automatic logic [31:0] tam_sens_word(input logic      lock,
                                                input logic      mask,
                                                input tam_sens_t s);
    logic [31:0] w;
    w                = '0;
    w[TAM_LOCK_BIT]  = lock;
    w[TAM_MASK_BIT]  = mask;
    w[TAM_VALID_BIT] = s.valid;
    w[TAM_TW-1:0]    = s.temp;
    return w;
  endfunction

  // ************************************************************
  // Aggregation
  // ************************************************************
  tam_temp_t  aggMax;
  tam_temp_t  aggMin;
  tam_temp_t  rawMax;
  logic [3:0] maxId;
  logic [3:0] minId;
  logic       anyOk;
  logic       rawOk;

  always_comb begin
    aggMax = '0;
    aggMin = '0;
    rawMax = '0;
    maxId  = '0;
    minId  = '0;
    anyOk  = 1'b0;
    rawOk  = 1'b0;
    for (int i = 0; i < TAM_NSENS; i++) begin
      if (sensIn[i].valid && !state_q.sensMask[i]) begin
        if (!anyOk || tam_gt(sensIn[i].temp, aggMax)) begin
          aggMax = sensIn[i].temp;
          maxId  = 4'(i);
        end
        if (!anyOk || tam_gt(aggMin, sensIn[i].temp)) begin
          aggMin = sensIn[i].temp;
          minId  = 4'(i);
        end
        anyOk = 1'b1;
      end
      // Hot pin looks at every valid sensor; the mask only steers alerts
      if (sensIn[i].valid && (!rawOk || tam_gt(sensIn[i].temp, rawMax))) begin
        rawMax = sensIn[i].temp;
        rawOk  = 1'b1;
      end
    end
  end

  // ************************************************************
  // Threshold compare
  // ************************************************************
  // Strict compares; a reading equal to a threshold does not trip
  logic aboveNow;
  logic belowNow;
  logic hotNow;

  always_comb begin
    aboveNow = anyOk && tam_gt(aggMax, state_q.aht);
    belowNow = anyOk && tam_gt(state_q.alt, aggMin);
    hotNow   = state_q.hotEn && rawOk && tam_gt(rawMax, state_q.hotThr);
  end

  // ************************************************************
  // Address decode
  // ************************************************************
  // One hit flag per register; the write path uses them all, the read path only the sensor flags
  logic                 hitTlen;
  logic                 hitAht;
  logic                 hitAlt;
  logic                 hitTrip;
  logic                 hitHot;
  logic [TAM_NSENS-1:0] hitSens;

  always_comb begin
    hitTlen = tam_hit(req.addr, TAM_OFF_THROTTLE_LEVELS_ENABLE);
    hitAht  = tam_hit(req.addr, TAM_OFF_AHT);
    hitAlt  = tam_hit(req.addr, TAM_OFF_ALT);
    hitTrip = tam_hit(req.addr, TAM_OFF_TRIP);
    hitHot  = tam_hit(req.addr, TAM_OFF_HOT);
    hitSens = '0;
    for (int i = 0; i < TAM_NSENS; i++) begin
      hitSens[i] = tam_hit(req.addr, tam_sens_off(i));
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  logic       wrTlen;
  logic       wrAht;
  logic       wrAlt;
  logic       wrTrip;
  logic       wrHot;
  logic       riseNow;
  logic       fallNow;
  logic       evtPulse;

  always_comb begin
    state_d = state_q;
    wrTlen  = req.wr && hitTlen;
    wrAht   = req.wr && hitAht;
    wrAlt   = req.wr && hitAlt;
    wrTrip  = req.wr && hitTrip;
    wrHot   = req.wr && hitHot;

    if (wrTlen && !state_q.throttle_enable_lock) begin
      state_d.throttle_enable_lock = req.wdata[TAM_LOCK_BIT];
    end
    if (wrAht) begin
      state_d.aht = req.wdata[TAM_TW-1:0];
    end
    if (wrAlt) begin
      state_d.alt = req.wdata[TAM_TW-1:0];
    end
    if (wrHot && !state_q.hotLock) begin
      state_d.hotLock = req.wdata[TAM_LOCK_BIT];
      state_d.hotEn   = req.wdata[TAM_HOT_EN_BIT];
      state_d.hotThr  = req.wdata[TAM_TW-1:0];
    end
    for (int i = 0; i < TAM_NSENS; i++) begin
      if (req.wr && hitSens[i]) begin
        if (req.wdata[TAM_LOCK_BIT]) begin
          state_d.sensLock[i] = 1'b1;
        end
        if (!state_q.sensLock[i]) begin
          state_d.sensMask[i] = req.wdata[TAM_MASK_BIT];
        end
      end
    end

    // Compare against current thresholds each cycle; events fire on the edge
    state_d.aboveHi = aboveNow;
    state_d.belowLo = belowNow;
    riseNow = state_d.aboveHi && !state_q.aboveHi;
    fallNow = state_d.belowLo && !state_q.belowLo && state_q.riseSeen;

    // Clear first so a coincident event wins
    if (wrTrip && req.wdata[TAM_RISE_EVT_BIT]) begin
      state_d.riseEvt = 1'b0;
    end
    if (wrTrip && req.wdata[TAM_FALL_EVT_BIT]) begin
      state_d.fallEvt = 1'b0;
    end
    if (riseNow) begin
      state_d.riseEvt  = 1'b1;
      state_d.riseSeen = 1'b1;
      state_d.riseId   = maxId;
    end
    if (fallNow) begin
      state_d.fallEvt = 1'b1;
      state_d.fallId  = minId;
    end

    state_d.hotN = !hotNow;

    // Interrupts pulse one cycle when riseEvt or fallEvt goes from clear to set; sciSelect picks the route.
    // Masked sensors never reach the aggregate, so their alerts stay silent.
    evtPulse = (state_d.riseEvt && !state_q.riseEvt) ||
               (state_d.fallEvt && !state_q.fallEvt);
    state_d.system_mgmt_interrupt = evtPulse && !sciSelect;
    state_d.acpi_control_interrupt = evtPulse && sciSelect;

    // Read data, reserved bits zero, unmapped addresses read zero
    state_d.rdata = '0;
    if (req.rd) begin
      case (req.addr)
        TAM_OFF_THROTTLE_LEVELS_ENABLE: begin
          state_d.rdata = tam_lock_word(state_q.throttle_enable_lock);
        end
        TAM_OFF_AHT: begin
          state_d.rdata = tam_thr_word(state_q.aht);
        end
        TAM_OFF_ALT: begin
          state_d.rdata = tam_thr_word(state_q.alt);
        end
        TAM_OFF_TRIP: begin
          state_d.rdata = tam_trip_word(state_q.fallEvt, state_q.fallId,
                                        state_q.riseEvt, state_q.riseId);
        end
        TAM_OFF_HOT: begin
          state_d.rdata = tam_hot_word(state_q.hotLock, state_q.hotEn, state_q.hotThr);
        end
        default: begin
          for (int i = 0; i < TAM_NSENS; i++) begin
            if (hitSens[i]) begin
              state_d.rdata = tam_sens_word(state_q.sensLock[i], state_q.sensMask[i], sensIn[i]);
            end
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q        <= '0;
      state_q.aht    <= TAM_AHT_RST;
      state_q.alt    <= TAM_ALT_RST;
      state_q.hotThr <= TAM_HOT_RST;
      state_q.hotN   <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Every output comes straight from the state register, so none glitches
  assign rdata                = state_q.rdata;
  assign hotAlertPinN         = state_q.hotN;
  assign systemMgmtInterrupt  = state_q.system_mgmt_interrupt;
  assign acpiControlInterrupt = state_q.acpi_control_interrupt;
endmodule
`default_nettype wire

// ### testbench/tam_monitor_chk.sv
// Port checker for the thermal alert monitor.
// Assumes it is bound to tam_monitor; one clock, reset rstn low.
`default_nettype none
module tam_monitor_chk
  import tam_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      rstn,
  input wire tam_req_t                  req,
  input wire logic [31:0]               rdata,
  input wire tam_sens_t [TAM_NSENS-1:0] sensIn,
  input wire logic                      hotAlertPinN,
  input wire logic                      systemMgmtInterrupt,
  input wire logic                      acpiControlInterrupt,
  input wire logic                      sciSelect
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ************************************************************
  // Properties
  // ************************************************************
  a_sens_read: assert property (req.rd && req.addr == TAM_OFF_SENS0 |=>
    rdata == {22'h0, $past(sensIn[0].valid), $past(sensIn[0].temp)})
    else $error("sensor read does not show live reading");
  a_trip_rsvd: assert property (req.rd && req.addr == TAM_OFF_TRIP |=>
    (rdata & 32'hffff7070) == 32'h0) else $error("trip status reserved bits set");
  a_thr_rsvd: assert property (req.rd && req.addr == TAM_OFF_AHT |=>
    rdata[31:9] == 23'h0) else $error("threshold reserved bits set");
  a_throttle_levels_enable_rsvd: assert property (req.rd && req.addr == TAM_OFF_THROTTLE_LEVELS_ENABLE |=>
    rdata[30:0] == 31'h0) else $error("throttle enable reserved bits set");
  a_int_excl: assert property (!(systemMgmtInterrupt && acpiControlInterrupt))
    else $error("both interrupt routes active");
  a_smi_route: assert property (systemMgmtInterrupt |-> !$past(sciSelect))
    else $error("system interrupt on wrong route");
  a_acpi_route: assert property (acpiControlInterrupt |-> $past(sciSelect))
    else $error("acpi interrupt on wrong route");
  a_int_cause: assert property (systemMgmtInterrupt || acpiControlInterrupt |->
    $past(sensIn) != $past(sensIn, 2) || $past(req.wr) || $past(req.wr, 2))
    else $error("interrupt without a new sample");
  a_hot_none: assert property (!(sensIn[0].valid || sensIn[1].valid || sensIn[2].valid)
    [*2] |-> hotAlertPinN) else $error("hot pin low with no valid sensor");
  a_hot_rst: assert property ($rose(rstn) |-> hotAlertPinN)
    else $error("hot pin low after reset");
endmodule
`default_nettype wire

// ### testbench/tam_monitor_tb.sv
// Self-checking bench for the thermal alert monitor.
// Assumes tam_pkg, tam_monitor and the checker are compiled first.
`default_nettype none
module tam_monitor_tb
  import tam_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic                      clk = 1'b0;
  logic                      rstn = 1'b0;
  tam_req_t                  req = '0;
  logic [31:0]               rdata;
  tam_sens_t [TAM_NSENS-1:0] sensIn = '0;
  logic                      hotAlertPinN;
  logic                      system_mgmt_interrupt;
  logic                      acpi_control_interrupt;
  logic                      sciSelect = 1'b0;
  int                        mismatches = 0;
  int                        compares = 0;
  int                        nSmi = 0;
  int                        nSci = 0;
  localparam logic [15:0] OFFS [8] = '{TAM_OFF_THROTTLE_LEVELS_ENABLE, TAM_OFF_AHT, TAM_OFF_ALT, TAM_OFF_TRIP,
    TAM_OFF_HOT, TAM_OFF_SENS0, TAM_OFF_SENS0 + TAM_SENS_STEP, 16'h1544};
  localparam logic [31:0] RSTV [8] = '{32'h0, 32'hff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  tam_monitor tam_monitor_inst (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
    .sensIn(sensIn), .hotAlertPinN(hotAlertPinN), .systemMgmtInterrupt(system_mgmt_interrupt),
    .acpiControlInterrupt(acpi_control_interrupt), .sciSelect(sciSelect));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    if (system_mgmt_interrupt === 1'b1) nSmi++;
    if (acpi_control_interrupt === 1'b1) nSci++;
  end
  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Each access leaves an idle cycle so strobes never retoggle in one step
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    step(1);
    req = '0;
    step(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    req.rd = 1'b1;
    req.addr = a;
    step(1);
    chk(rdata & m, e);
    req = '0;
    step(1);
  endtask
  task automatic sens(input int i, input logic v, input logic [8:0] t);
    sensIn[i].valid = v;
    sensIn[i].temp = t;
    step(2);
  endtask
  function automatic logic [15:0] sa(input int i);
    return TAM_OFF_SENS0 + TAM_SENS_STEP * 16'(i);
  endfunction
  task automatic complete_run();
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    step(5);
    rstn = 1'b1;
    step(1);
    foreach (OFFS[k]) rd(OFFS[k], '1, RSTV[k]);
    sens(0, 1'b1, 9'h1d8);
    sens(1, 1'b1, 9'h001);
    sens(2, 1'b0, 9'h1ff);
    rd(sa(0), '1, 32'h3d8);
    rd(sa(1), '1, 32'h201);
    rd(TAM_OFF_TRIP, '1, 32'h0);
    wr(TAM_OFF_AHT, 32'h10);
    sens(1, 1'b1, 9'h014);
    rd(TAM_OFF_TRIP, 32'h8f8f, 32'h81);
    chk(nSmi, 1);
    sciSelect = 1'b1;
    sens(0, 1'b1, 9'h005);
    sens(2, 1'b1, 9'h1fe);
    rd(TAM_OFF_TRIP, 32'h8f8f, 32'h8281);
    chk(nSci, 1);
    wr(TAM_OFF_TRIP, 32'h0);
    rd(TAM_OFF_TRIP, 32'h8080, 32'h8080);
    wr(TAM_OFF_TRIP, 32'h80);
    rd(TAM_OFF_TRIP, 32'h8080, 32'h8000);
    wr(TAM_OFF_TRIP, 32'h8000);
    rd(TAM_OFF_TRIP, 32'h8080, 32'h0);
    wr(sa(2), 32'h10000);
    sens(1, 1'b1, 9'h00a);
    sens(2, 1'b1, 9'h064);
    rd(TAM_OFF_TRIP, 32'h8080, 32'h0);
    chk(nSmi + nSci, 2);
    wr(sa(2), 32'h80010000);
    wr(sa(2), 32'h0);
    rd(sa(2), '1, 32'h80010264);
    wr(TAM_OFF_ALT, 32'hffffffff);
    rd(TAM_OFF_ALT, '1, 32'h1ff);
    wr(TAM_OFF_HOT, 32'h81d8);
    chk(hotAlertPinN, 1'b0);
    wr(TAM_OFF_HOT, 32'h800080ff);
    wr(TAM_OFF_HOT, 32'h81d8);
    rd(TAM_OFF_HOT, '1, 32'h800080ff);
    chk(hotAlertPinN, 1'b1);
    wr(TAM_OFF_THROTTLE_LEVELS_ENABLE, 32'hffffffff);
    wr(TAM_OFF_THROTTLE_LEVELS_ENABLE, 32'h0);
    rd(TAM_OFF_THROTTLE_LEVELS_ENABLE, '1, 32'h80000000);
    sensIn = '0;
    step(3);
    rstn = 1'b0;
    step(2);
    rstn = 1'b1;
    step(1);
    rd(TAM_OFF_THROTTLE_LEVELS_ENABLE, '1, 32'h0);
    rd(sa(2), '1, 32'h0);
    complete_run();
  end
endmodule
bind tam_monitor tam_monitor_chk tam_monitor_chk_inst (.clk(clk), .rstn(rstn), .req(req),
  .rdata(rdata), .sensIn(sensIn), .hotAlertPinN(hotAlertPinN), .sciSelect(sciSelect),
  .systemMgmtInterrupt(systemMgmtInterrupt), .acpiControlInterrupt(acpiControlInterrupt));
`default_nettype wire
